// file: rtl/anci_pkg.sv
// package for the ancillary packet inserter: widths, flag words, modes, limits
// assumes a 10-bit parallel video word stream with line and sample counters upstream
package anci_pkg;
  localparam int unsigned WORD_W   = 10;
  localparam int unsigned LINE_W   = 11;
  localparam int unsigned SAMP_W   = 13;
  localparam int unsigned UDW_NUM  = 255;            // payload words 000..254
  localparam int unsigned UDW_IDX_W = 8;
  localparam logic [9:0]  ADF_W0   = 10'h000;        // ancillary data flag words
  localparam logic [9:0]  ADF_W1   = 10'h3ff;
  localparam logic [9:0]  ADF_W2   = 10'h3ff;
  localparam logic [9:0]  WORD_RST = 10'h000;
  localparam logic [9:0]  MASK8    = 10'h0ff;
  localparam int unsigned PAR_BIT  = 8;
  localparam int unsigned NPAR_BIT = 9;
  localparam logic [8:0]  SUM_MASK = 9'h1ff;
  localparam logic [7:0]  UDW_LAST = 8'hfe;
  localparam logic [9:0]  FLAG_LAST = 10'h002;       // index of the third flag word
  localparam logic [9:0]  HDR_LAST  = 10'h002;       // index of the data count word

  // packet sequencer states, used only by the inserter; the checker sees busy_o, not the states
  typedef enum logic [2:0] {
    ANCI_ST_IDLE, ANCI_ST_FLAG, ANCI_ST_HDR, ANCI_ST_UDW, ANCI_ST_CS
  } anci_st_t;

  typedef enum logic [1:0] {ANCI_OUT_OFF, ANCI_OUT_CONT, ANCI_OUT_SINGLE} anci_out_mode_t;
  typedef enum logic [1:0] {ANCI_FLD_ONE, ANCI_FLD_TWO, ANCI_FLD_BOTH} anci_field_sel_t;
endpackage

// file: rtl/anci_inserter.sv
// ancillary packet inserter: builds one packet and splices it into the output stream
// assumes the raster generator supplies line, field, sample (from sav) and word flags
`timescale 1ns/1ps
// Overview of operation
// - packet may land anywhere, overwriting anc/picture
// - never overwrite embedded audio or line crc
// - order: did, sdid, dc, payload, checksum
// - payload store holds words 000 to 254
// - output modes: off, continuous, single packet
// - parity automatic 8-bit or manual 10-bit
// - store full 10 bits; auto sends low 8
// - did accepts 8-bit or 10-bit values
// - sdid accepts 8-bit or 10-bit values
// - data count sets number of payload words
// - payload words accept 8-bit or 10-bit values
// - confirmed wipe clears store; cancel keeps it
// - manual checksum used when auto off
// - enable selects computed or manual checksum
// - out-of-range line or sample suppresses insertion
// - timing reference words are not guarded
// - progressive: single configured line
// - interlaced: field one, two or both, own lines
// - first word on the first free slot after the sample counted from sav
// - insert into luma or chroma channel
// - 3g-b: insert into selected link a/b
// - automatic parity is the reset default
module anci_inserter #(
  parameter int unsigned UDW_NUM = anci_pkg::UDW_NUM
) (
  input  wire logic                          ref_clk_i,
  input  wire logic                          resetn_i,
  // settings from the panel controller
  input  wire anci_pkg::anci_out_mode_t      out_mode_i,
  input  wire logic                          parity_manual_i,
  input  wire logic [anci_pkg::WORD_W-1:0]   did_i,
  input  wire logic [anci_pkg::WORD_W-1:0]   sdid_i,
  input  wire logic [anci_pkg::WORD_W-1:0]   dc_i,
  input  wire logic [anci_pkg::WORD_W-1:0]   cs_manual_i,
  input  wire logic                          cs_auto_i,
  input  wire logic                          udw_we_i,
  input  wire logic [anci_pkg::UDW_IDX_W-1:0] udw_addr_i,
  input  wire logic [anci_pkg::WORD_W-1:0]   udw_wdata_i,
  input  wire logic                          wipe_payload_words_i,
  input  wire logic                          interlaced_i,
  input  wire anci_pkg::anci_field_sel_t     field_sel_i,
  input  wire logic [anci_pkg::LINE_W-1:0]   line_f1_i,
  input  wire logic [anci_pkg::LINE_W-1:0]   line_f2_i,
  input  wire logic [anci_pkg::SAMP_W-1:0]   sample_i,
  input  wire logic                          chan_chroma_i,
  input  wire logic                          link_b_i,
  input  wire logic                          fmt_3gb_i,
  input  wire logic [anci_pkg::LINE_W-1:0]   fmt_lines_i,
  input  wire logic [anci_pkg::SAMP_W-1:0]   fmt_samples_i,
  // raster stream in
  input  wire logic                          vid_valid_i,
  input  wire logic                          vid_field2_i,
  input  wire logic [anci_pkg::LINE_W-1:0]   vid_line_i,
  input  wire logic [anci_pkg::SAMP_W-1:0]   vid_sample_i,
  input  wire logic                          vid_link_b_i,
  input  wire logic [anci_pkg::WORD_W-1:0]   vid_luma_i,
  input  wire logic [anci_pkg::WORD_W-1:0]   vid_chroma_i,
  input  wire logic                          vid_luma_prot_i,
  input  wire logic                          vid_chroma_prot_i,
  // stream out to the serializer
  output logic                               out_valid_o,
  output logic [anci_pkg::WORD_W-1:0]        out_luma_o,
  output logic [anci_pkg::WORD_W-1:0]        out_chroma_o,
  output logic                               busy_o,
  output logic                               single_done_o
);

  typedef anci_pkg::anci_st_t anci_state_t;

  typedef struct packed {
    logic [UDW_NUM-1:0][anci_pkg::WORD_W-1:0] udw;
    anci_state_t                              st;
    logic [anci_pkg::WORD_W-1:0]              cnt;
    logic [8:0]                               sum;
    logic                                     sent;
    logic                                     mode_single;
    logic                                     chroma;
    logic                                     ovalid;
    logic [anci_pkg::WORD_W-1:0]              oluma;
    logic [anci_pkg::WORD_W-1:0]              ochroma;
  } anci_regs_t;

  anci_regs_t r;
  anci_regs_t next_r;

  // auto parity: bit 8 even parity of low byte, bit 9 its inverse
  function automatic logic [9:0] anci_fmt(input logic [9:0] w, input logic manual);
    logic p;
    p = ^w[7:0];
    if (manual) begin
      anci_fmt = w;
    end else begin
      anci_fmt = {~p, p, w[7:0]};
    end
  endfunction

  function automatic logic [8:0] anci_acc(input logic [8:0] s, input logic [9:0] w);
    anci_acc = 9'(s + w[8:0]) & anci_pkg::SUM_MASK;
  endfunction

  // placement flags, each named so the start condition reads as the rules do
  logic                        at_target;   // this slot is the packet's anchor
  logic                        in_range;    // configured position fits the format
  logic                        line_hit;    // current line is a configured line
  logic                        samp_hit;    // current sample is the configured offset
  logic                        link_hit;    // link matches, or format has one link
  logic                        mode_ok;     // output mode allows a new packet now
  logic                        start;       // idle and anchored: open a packet
  logic [anci_pkg::LINE_W-1:0] line_cfg;    // configured line for the current field
  // word path
  logic [anci_pkg::WORD_W-1:0] cur_word;
  logic [anci_pkg::WORD_W-1:0] cs_word;
  logic [anci_pkg::WORD_W-1:0] udw_rd;
  logic [anci_pkg::WORD_W-1:0] dc_eff;
  // sequencer strobes
  logic                        slot_prot;   // target channel slot is audio or crc
  logic                        spend;       // a packet word goes out on this slot
  logic                        sect_end;    // last word of the current section
  logic                        in_sum;      // word counts toward the checksum

  // configured line: field two uses its own line only in interlaced rasters
  always_comb begin
    if (interlaced_i && vid_field2_i) begin
      line_cfg = line_f2_i;
    end else begin
      line_cfg = line_f1_i;
    end
  end

  // range guard against the current format; a stale offset after a format change never inserts
  always_comb begin
    in_range = (line_cfg < fmt_lines_i) && (sample_i < fmt_samples_i);
  end

  // placement decode, ignores timing reference words entirely
  always_comb begin
    if (!interlaced_i) begin
      line_hit = vid_line_i == line_f1_i;
    end else begin
      case (field_sel_i)
        anci_pkg::ANCI_FLD_ONE:  line_hit = !vid_field2_i && vid_line_i == line_f1_i;
        anci_pkg::ANCI_FLD_TWO:  line_hit = vid_field2_i && vid_line_i == line_f2_i;
        anci_pkg::ANCI_FLD_BOTH: line_hit = vid_field2_i ? vid_line_i == line_f2_i
                                                        : vid_line_i == line_f1_i;
        default:                 line_hit = 1'b0;
      endcase
    end
  end

  // anchor slot: sample counted from sav, link only matters in 3g-b
  always_comb begin
    samp_hit  = vid_sample_i == sample_i;
    link_hit  = !fmt_3gb_i || (vid_link_b_i == link_b_i);
    at_target = vid_valid_i && line_hit && in_range && samp_hit && link_hit;
  end

  // output mode gate: off never starts, single starts once until rearmed
  always_comb begin
    case (out_mode_i)
      anci_pkg::ANCI_OUT_CONT:   mode_ok = 1'b1;
      anci_pkg::ANCI_OUT_SINGLE: mode_ok = !r.sent;
      default:                   mode_ok = 1'b0;
    endcase
    start = (r.st == anci_pkg::ANCI_ST_IDLE) && at_target && mode_ok;
  end

  // word under construction for the current state
  always_comb begin
    // auto mode counts with the low byte only, as the sent data count word shows
    if (parity_manual_i) begin
      dc_eff = dc_i;
    end else begin
      dc_eff = dc_i & anci_pkg::MASK8;
    end
    // words past the store read as zero, so a long data count stays defined
    if (r.cnt < UDW_NUM) begin
      udw_rd = r.udw[r.cnt[anci_pkg::UDW_IDX_W-1:0]];
    end else begin
      udw_rd = anci_pkg::WORD_RST;
    end
    // computed checksum with bit 9 the inverse of bit 8, or the stored one formatted like any other word
    if (cs_auto_i) begin
      cs_word = {~r.sum[8], r.sum};
    end else begin
      cs_word = anci_fmt(cs_manual_i, parity_manual_i);
    end
    case (r.st)
      anci_pkg::ANCI_ST_FLAG: begin
        case (r.cnt[1:0])
          2'h0:    cur_word = anci_pkg::ADF_W0;
          2'h1:    cur_word = anci_pkg::ADF_W1;
          default: cur_word = anci_pkg::ADF_W2;
        endcase
      end
      anci_pkg::ANCI_ST_HDR: begin
        case (r.cnt[1:0])
          2'h0:    cur_word = anci_fmt(did_i, parity_manual_i);
          2'h1:    cur_word = anci_fmt(sdid_i, parity_manual_i);
          default: cur_word = anci_fmt(dc_i, parity_manual_i);
        endcase
      end
      anci_pkg::ANCI_ST_UDW: cur_word = anci_fmt(udw_rd, parity_manual_i);
      anci_pkg::ANCI_ST_CS:  cur_word = cs_word;
      default:               cur_word = anci_pkg::WORD_RST;
    endcase
  end

  // a word is spent only where the slot is not audio or crc; protected slots pass
  always_comb begin
    if (r.chroma) begin
      slot_prot = vid_chroma_prot_i;
    end else begin
      slot_prot = vid_luma_prot_i;
    end
    spend  = (r.st != anci_pkg::ANCI_ST_IDLE) && vid_valid_i && !slot_prot;
    in_sum = (r.st == anci_pkg::ANCI_ST_HDR) || (r.st == anci_pkg::ANCI_ST_UDW);
    case (r.st)
      anci_pkg::ANCI_ST_FLAG: sect_end = r.cnt == anci_pkg::FLAG_LAST;
      anci_pkg::ANCI_ST_HDR:  sect_end = r.cnt == anci_pkg::HDR_LAST;
      anci_pkg::ANCI_ST_UDW:  sect_end = r.cnt == 10'(dc_eff - 10'h001);
      anci_pkg::ANCI_ST_CS:   sect_end = 1'b1;
      default:                sect_end = 1'b1;
    endcase
  end

  // next state: store writes, sequencer and output mux
  always_comb begin
    next_r = r;
    // confirmed wipe clears every word and wins over a write; cancel never reaches this port
    if (wipe_payload_words_i) begin
      for (int i = 0; i < UDW_NUM; i++) begin
        next_r.udw[i] = anci_pkg::WORD_RST;
      end
    end else if (udw_we_i && udw_addr_i <= anci_pkg::UDW_LAST) begin
      next_r.udw[udw_addr_i] = udw_wdata_i;
    end
    // leaving single mode rearms the one-shot
    if (out_mode_i != anci_pkg::ANCI_OUT_SINGLE) begin
      next_r.sent = 1'b0;
    end
    // stream passes through one register unless a packet word replaces it
    next_r.ovalid  = vid_valid_i;
    next_r.oluma   = vid_luma_i;
    next_r.ochroma = vid_chroma_i;
    // open a packet on the anchor slot; channel is latched for the whole packet
    if (start) begin
      next_r.st          = anci_pkg::ANCI_ST_FLAG;
      next_r.cnt         = '0;
      next_r.sum         = '0;
      next_r.chroma      = chan_chroma_i;
      next_r.mode_single = out_mode_i == anci_pkg::ANCI_OUT_SINGLE;
    end
    // splice the current word into the chosen channel
    if (spend) begin
      if (r.chroma) begin
        next_r.ochroma = cur_word;
      end else begin
        next_r.oluma = cur_word;
      end
      if (in_sum) begin
        next_r.sum = anci_acc(r.sum, cur_word);
      end
      next_r.cnt = 10'(r.cnt + 10'h001);
      if (sect_end) begin
        next_r.cnt = '0;
        case (r.st)
          anci_pkg::ANCI_ST_FLAG: begin
            next_r.st = anci_pkg::ANCI_ST_HDR;
          end
          anci_pkg::ANCI_ST_HDR: begin
            // an empty payload goes straight to the checksum
            if (dc_eff == '0) begin
              next_r.st = anci_pkg::ANCI_ST_CS;
            end else begin
              next_r.st = anci_pkg::ANCI_ST_UDW;
            end
          end
          anci_pkg::ANCI_ST_UDW: begin
            next_r.st = anci_pkg::ANCI_ST_CS;
          end
          anci_pkg::ANCI_ST_CS: begin
            next_r.st   = anci_pkg::ANCI_ST_IDLE;
            next_r.sent = r.mode_single;
          end
          default: begin
            next_r.st = anci_pkg::ANCI_ST_IDLE;
          end
        endcase
      end
    end
  end

  // single register process; parity defaults to automatic via the port reset value
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign out_valid_o   = r.ovalid;
  assign out_luma_o    = r.oluma;
  assign out_chroma_o  = r.ochroma;
  assign busy_o        = r.st != anci_pkg::ANCI_ST_IDLE;
  assign single_done_o = r.sent;

endmodule // anci_inserter

// file: verif/anci_props.sv
// checker: stream properties of the packet inserter, bound to its top module
// assumes one clock; the start check covers progressive single-link rasters only
`timescale 1ns/1ps
module anci_props #(parameter int unsigned UDW_NUM = anci_pkg::UDW_NUM) (
  input wire logic ref_clk_i, resetn_i, interlaced_i, fmt_3gb_i, chan_chroma_i, vid_valid_i,
  input wire logic vid_luma_prot_i, vid_chroma_prot_i, busy_o, single_done_o,
  input wire anci_pkg::anci_out_mode_t out_mode_i,
  input wire logic [anci_pkg::LINE_W-1:0] line_f1_i, fmt_lines_i, vid_line_i,
  input wire logic [anci_pkg::SAMP_W-1:0] sample_i, fmt_samples_i, vid_sample_i,
  input wire logic [anci_pkg::WORD_W-1:0] vid_luma_i, vid_chroma_i, out_luma_o, out_chroma_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);
  logic trig, free;
  logic [9:0] word;
  // start slot as the inserter should see it; field and link matching is left to the bench
  assign trig = vid_valid_i && !busy_o && !interlaced_i && !fmt_3gb_i && !single_done_o
    && vid_line_i == line_f1_i && vid_sample_i == sample_i && line_f1_i < fmt_lines_i
    && sample_i < fmt_samples_i && out_mode_i != anci_pkg::ANCI_OUT_OFF;
  assign free = vid_valid_i && !(chan_chroma_i ? vid_chroma_prot_i : vid_luma_prot_i);
  assign word = chan_chroma_i ? out_chroma_o : out_luma_o;
  sequence s_flag_slots;
    trig ##1 free [*3];
  endsequence
  chk_flag_words: assert property (s_flag_slots |=> word == anci_pkg::ADF_W2
    && $past(word) == anci_pkg::ADF_W1 && $past(word, 2) == anci_pkg::ADF_W0) else $error("flags");
  chk_busy_start: assert property (trig |=> busy_o) else $error("no start");
  chk_prot_luma: assert property (vid_valid_i && vid_luma_prot_i
    |=> out_luma_o == $past(vid_luma_i)) else $error("protected word lost");
  chk_other_chan: assert property (vid_valid_i |=> ($past(chan_chroma_i)
    ? out_luma_o == $past(vid_luma_i) : out_chroma_o == $past(vid_chroma_i))) else $error("chan");
  chk_idle_pass: assert property (vid_valid_i && !busy_o |=> out_luma_o == $past(vid_luma_i)
    && out_chroma_o == $past(vid_chroma_i)) else $error("idle slot changed");
  chk_range_off: assert property (sample_i >= fmt_samples_i && !busy_o |=> !busy_o)
    else $error("out of range insert");
  chk_mode_off: assert property (out_mode_i == anci_pkg::ANCI_OUT_OFF && !busy_o |=> !busy_o)
    else $error("insert while off");
  chk_single_once: assert property (single_done_o && !busy_o
    && out_mode_i == anci_pkg::ANCI_OUT_SINGLE |=> !busy_o) else $error("second single");
endmodule // anci_props
bind anci_inserter anci_props #(.UDW_NUM(UDW_NUM)) u_props (.*);

// file: verif/anci_raster_model.sv
// raster model: word slots with line, sample and field counts, protected slots, one stall a line
// assumes one clock; a stalled slot shows inverted data, since nothing valid is on the bus
`timescale 1ns/1ps
module anci_raster_model #(parameter int SAMPS = 40, parameter int LINES = 4) (
  input  wire logic ref_clk_i, resetn_i, en_i,
  output logic valid_o, f2_o, lb_o, lprot_o, cprot_o,
  output logic [10:0] line_o,
  output logic [12:0] samp_o,
  output logic [9:0] luma_o, chroma_o
);
  logic gap;
  // the stall before slot 17 falls inside every packet, testing that a gap does not advance it
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      {valid_o, f2_o, gap, line_o, samp_o} <= '0;
    end else if (en_i && valid_o && samp_o == 13'h0010 && !gap) begin
      {valid_o, gap, samp_o} <= {2'b01, 13'h0011};
    end else if (en_i) begin
      valid_o <= 1'b1;
      gap <= gap && !valid_o;
      if (valid_o) samp_o <= (samp_o == 13'(SAMPS - 1)) ? '0 : samp_o + 13'h0001;
      if (valid_o && samp_o == 13'(SAMPS - 1)) begin
        line_o <= (line_o == 11'(LINES - 1)) ? '0 : line_o + 11'h001;
        if (line_o == 11'(LINES - 1)) f2_o <= ~f2_o;
      end
    end
  end
  // audio and crc slots sit inside the packet span; link b carries the odd lines
  assign lb_o = line_o[0];
  assign lprot_o = valid_o && samp_o == 13'h000d;
  assign cprot_o = valid_o && samp_o == 13'h000e;
  assign luma_o = valid_o ? {line_o[2:0], samp_o[6:0]} : ~{line_o[2:0], samp_o[6:0]};
  assign chroma_o = ~luma_o;
endmodule // anci_raster_model

// file: verif/tb_top.sv
// testbench: raster model feeds the inserter; packets are captured and compared
// assumes package, inserter, checker and raster model are compiled first
`timescale 1ns/1ps
module tb_top;
  typedef struct packed {logic m, a, c; logic [9:0] did, sdid, dc, cs;} anci_row_t;
  logic ref_clk_i = 0, resetn_i = 0, en = 0, parity_manual_i = 0, cs_auto_i = 0, udw_we_i = 0;
  logic wipe_payload_words_i = 0, interlaced_i = 0, chan_chroma_i = 0, link_b_i = 0;
  logic fmt_3gb_i = 0, vid_valid_i, vid_field2_i, vid_link_b_i, vid_luma_prot_i, vid_chroma_prot_i;
  logic out_valid_o, busy_o, single_done_o, arm = 0, capt = 0, pv = 0, pp, pt = 0, seen;
  anci_pkg::anci_out_mode_t out_mode_i = anci_pkg::ANCI_OUT_CONT;
  anci_pkg::anci_field_sel_t field_sel_i = anci_pkg::ANCI_FLD_ONE;
  logic [9:0] did_i = '0, sdid_i = '0, dc_i = '0, cs_manual_i = '0, udw_wdata_i = '0, pw;
  logic [9:0] vid_luma_i, vid_chroma_i, out_luma_o, out_chroma_o, mem [255], got [$], exq [$];
  logic [7:0] udw_addr_i = '0;
  logic [10:0] line_f1_i = 11'h002, line_f2_i = '0, fmt_lines_i = 11'h004, vid_line_i, tl = 11'h002;
  logic [12:0] sample_i = 13'h000a, fmt_samples_i = 13'h0028, vid_sample_i;
  logic [1:0] tf = 2'h2;
  int n_fail = 0, total_checks = 0, need = 0;
  anci_row_t rows [4] = '{'{1'b0, 1'b1, 1'b0, 10'h041, 10'h005, 10'h004, 10'h000},
    '{1'b1, 1'b1, 1'b0, 10'h2c1, 10'h305, 10'h003, 10'h000},
    '{1'b0, 1'b0, 1'b1, 10'h3ff, 10'h0ff, 10'h000, 10'h3a5},  // empty payload
    '{1'b1, 1'b0, 1'b1, 10'h000, 10'h1aa, 10'h008, 10'h3a5}};
  anci_raster_model u_rast (.ref_clk_i, .resetn_i, .en_i(en), .valid_o(vid_valid_i),
    .f2_o(vid_field2_i), .lb_o(vid_link_b_i), .lprot_o(vid_luma_prot_i), .cprot_o(vid_chroma_prot_i),
    .line_o(vid_line_i), .samp_o(vid_sample_i), .luma_o(vid_luma_i), .chroma_o(vid_chroma_i));
  anci_inserter DUT (.*);
  initial forever #5 ref_clk_i = ~ref_clk_i;
  task automatic check(string what, logic [9:0] got_v, logic [9:0] exp_v);
    total_checks++;
    if (got_v !== exp_v) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp_v, got_v);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  function automatic logic [9:0] fmtw(logic [9:0] w);
    return parity_manual_i ? w : {~^w[7:0], ^w[7:0], w[7:0]};
  endfunction
  // outputs settle by the falling edge; each belongs to the slot seen one edge earlier
  always @(negedge ref_clk_i) begin
    if (capt) check("valid", 10'(out_valid_o), 10'(pv));
    if (capt && pv && pp) check("protected", chan_chroma_i ? out_chroma_o : out_luma_o, pw);
    if (capt && pv && !pp) got.push_back(chan_chroma_i ? out_chroma_o : out_luma_o);
    if (capt && got.size() >= need) {capt, arm} = 2'b00;
    if (pt && arm) capt = 1'b1;
    pv = vid_valid_i;
    pp = chan_chroma_i ? vid_chroma_prot_i : vid_luma_prot_i;
    pw = chan_chroma_i ? vid_chroma_i : vid_luma_i;
    pt = vid_valid_i && vid_sample_i == sample_i && vid_line_i == tl && (tf[1] || vid_field2_i == tf[0]);
  end
  task automatic run_pkt();
    logic [8:0] sum;
    @(negedge ref_clk_i);
    exq = {10'h000, 10'h3ff, 10'h3ff, fmtw(did_i), fmtw(sdid_i), fmtw(dc_i)};
    for (int k = 0; k < (parity_manual_i ? dc_i : dc_i[7:0]); k++) exq.push_back(fmtw(mem[k]));
    sum = '0;
    for (int k = 3; k < exq.size(); k++) sum += exq[k][8:0];
    exq.push_back(cs_auto_i ? {~sum[8], sum} : fmtw(cs_manual_i));
    got.delete();
    need = exq.size();
    arm = 1'b1;
    for (int t = 0; t < 900 && arm; t++) @(posedge ref_clk_i);
    check("length", 10'(got.size()), 10'(need));
    foreach (got[k]) check("word", got[k], exq[k]);
    repeat (8) @(posedge ref_clk_i);
  endtask
  // stays idle for more than two frames
  task automatic quiet(string what);
    seen = 1'b0;
    repeat (400) @(negedge ref_clk_i) seen = seen | (busy_o !== 1'b0);
    check(what, 10'(seen), 10'h000);
  endtask
  initial begin
    repeat (16) @(posedge ref_clk_i);
    resetn_i <= 1'b1;
    @(negedge ref_clk_i);
    check("busy", 10'(busy_o), 10'h000);
    // full 10-bit words, so auto and manual parity rows differ in the top bits
    for (int k = 0; k < 255; k++) begin
      @(posedge ref_clk_i) {udw_we_i, udw_addr_i, udw_wdata_i} <= {1'b1, 8'(k), 10'h2c3 + 10'(k)};
      mem[k] = 10'h2c3 + 10'(k);
    end
    @(posedge ref_clk_i) {udw_we_i, en} <= 2'b01;
    foreach (rows[r]) begin
      @(posedge ref_clk_i) {parity_manual_i, cs_auto_i, chan_chroma_i, did_i, sdid_i, dc_i} <= rows[r][42:10];
      cs_manual_i <= rows[r].cs;
      run_pkt();
    end
    @(posedge ref_clk_i) wipe_payload_words_i <= 1'b1;
    @(posedge ref_clk_i) wipe_payload_words_i <= 1'b0;
    foreach (mem[k]) mem[k] = '0;
    run_pkt();
    @(posedge ref_clk_i) sample_i <= 13'h0028;
    quiet("range");
    @(posedge ref_clk_i) {sample_i, out_mode_i} <= {13'h000a, anci_pkg::ANCI_OUT_OFF};
    quiet("off");
    @(posedge ref_clk_i) out_mode_i <= anci_pkg::ANCI_OUT_SINGLE;
    run_pkt();
    check("done", 10'(single_done_o), 10'h001);
    quiet("single");
    @(posedge ref_clk_i) {out_mode_i, interlaced_i, line_f2_i} <= {anci_pkg::ANCI_OUT_CONT, 12'h801};
    field_sel_i <= anci_pkg::ANCI_FLD_TWO;
    {tl, tf} = {11'h001, 2'h1};
    run_pkt();
    @(posedge ref_clk_i) {interlaced_i, fmt_3gb_i, link_b_i, line_f1_i} <= {3'b011, 11'h003};
    {tl, tf} = {11'h003, 2'h2};
    run_pkt();
    close_out();
  end
  initial begin
    #200us;
    $display("ERROR watchdog expected end seen hang");
    n_fail++;
    close_out();
  end
endmodule // tb_top
